// File: design/idle_exec.sv
`timescale 1ns/1ps
// Behaviour
// - register instructions take a 7-bit file address and a one-bit destination
// - destination zero writes accumulator, one writes back the addressed file register
// - decrement subtracts one, routes per destination, updates zero flag
// - increment adds one, routes per destination, updates zero flag
// - decrement-skip stores like decrement, no flags, skips next when zero
// - increment-skip stores like increment, no flags, skips next when zero
// - or-literal ORs accumulator with 8-bit literal into accumulator, updates zero
// - load-literal puts 8-bit literal in accumulator, flags untouched
module idle_exec
    import idle_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // instruction
    input wire logic valid_i,
    input wire idle_pkg::idle_op_t op_i,
    input wire logic [idle_pkg::IDLE_ADDR_W-1:0] addr_i,
    input wire logic dest_i,
    input wire logic [7:0] lit_i,
    // register file
    output logic [idle_pkg::IDLE_ADDR_W-1:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic wr_en_o,
    output logic [idle_pkg::IDLE_ADDR_W-1:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    // core state
    input wire logic zero_flag_i,
    output logic [7:0] acc_o,
    output logic zero_flag_o,
    output logic zero_we_o,
    output logic skip_o
);
    import idle_pkg::*;

    logic [7:0] acc_reg;
    logic zero_reg;
    logic [7:0] result;
    logic res_zero;
    logic flag_we;
    logic skip_kind;
    logic is_lit;

    assign rd_addr_o = addr_i;
    assign is_lit = (op_i == IDLE_OP_OR_LIT) || (op_i == IDLE_OP_LOAD_LIT);

    idle_alu u_alu (
        .op_i(op_i),
        .file_i(rd_data_i),
        .acc_i(acc_reg),
        .lit_i(lit_i),
        .result_o(result),
        .zero_o(res_zero),
        .writes_flag_o(flag_we),
        .skip_kind_o(skip_kind)
    );

    // accumulator: literal ops always land here, register ops when dest is zero
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            acc_reg <= IDLE_ACC_RST;
        end else if (valid_i && (is_lit || dest_i == IDLE_DEST_ACC)) begin
            acc_reg <= result;
        end
    end
    assign acc_o = acc_reg;

    // file write-back strobe, registered so data comes from flip-flops
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wr_en_o <= 1'b0;
            wr_addr_o <= '0;
            wr_data_o <= IDLE_ZERO;
        end else begin
            wr_en_o <= valid_i && !is_lit && (dest_i == IDLE_DEST_FILE);
            wr_addr_o <= addr_i;
            wr_data_o <= result;
        end
    end

    // zero flag: skip variants and load leave it alone
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            zero_reg <= 1'b0;
            zero_we_o <= 1'b0;
        end else begin
            zero_we_o <= valid_i && flag_we;
            zero_reg <= (valid_i && flag_we) ? res_zero : zero_flag_i;
        end
    end
    assign zero_flag_o = zero_reg;

    // skip request: core replaces the next instruction by a no-op
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            skip_o <= 1'b0;
        end else begin
            skip_o <= valid_i && skip_kind && res_zero;
        end
    end

    property p_acc_write;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && (is_lit || !dest_i) |=> acc_o == $past(result);
    endproperty
    a_acc_write: assert property (p_acc_write) else $error("acc not written");

    property p_file_write;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && !is_lit && dest_i |=> wr_en_o && wr_data_o == $past(result)
            && wr_addr_o == $past(addr_i);
    endproperty
    a_file_write: assert property (p_file_write) else $error("file not written");

    property p_dec;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_DEC |-> result == 8'(rd_data_i - IDLE_ONE);
    endproperty
    a_dec: assert property (p_dec) else $error("bad decrement");

    property p_inc;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_INC |-> result == 8'(rd_data_i + IDLE_ONE);
    endproperty
    a_inc: assert property (p_inc) else $error("bad increment");

    property p_skip;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && (op_i == IDLE_OP_DEC_SKIP || op_i == IDLE_OP_INC_SKIP)
            |=> skip_o == $past(res_zero) && !zero_we_o;
    endproperty
    a_skip: assert property (p_skip) else $error("bad skip");

    property p_no_skip;
        @(posedge clock_i) disable iff (srst_i)
        !(valid_i && skip_kind) |=> !skip_o;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("spurious skip");

    property p_or;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_OR_LIT |=> acc_o == ($past(acc_o) | $past(lit_i))
            && zero_we_o && zero_flag_o == (acc_o == IDLE_ZERO);
    endproperty
    a_or: assert property (p_or) else $error("bad or literal");

    property p_load;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_LOAD_LIT |=> acc_o == $past(lit_i) && !zero_we_o;
    endproperty
    a_load: assert property (p_load) else $error("bad load literal");

    property p_zero;
        @(posedge clock_i) disable iff (srst_i)
        zero_we_o |-> zero_flag_o == ($past(result) == IDLE_ZERO);
    endproperty
    a_zero: assert property (p_zero) else $error("bad zero flag");

    property p_file_only_reg;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && is_lit |=> !wr_en_o;
    endproperty
    a_file_only_reg: assert property (p_file_only_reg) else $error("literal wrote file");

    // reset wins over any instruction presented with it
    property p_reset_quiet;
        @(posedge clock_i)
        srst_i |=> !wr_en_o && !zero_we_o && !skip_o && !zero_flag_o
            && acc_o == IDLE_ACC_RST;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset not quiet");

    // an idle cycle must not disturb the core state
    property p_idle;
        @(posedge clock_i) disable iff (srst_i)
        !valid_i |=> !wr_en_o && !zero_we_o && !skip_o && $stable(acc_o);
    endproperty
    a_idle: assert property (p_idle) else $error("idle cycle changed state");

    // skip variants share the adder with the plain ops, so check them on their own
    property p_dec_skip;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_DEC_SKIP |-> result == 8'(rd_data_i - IDLE_ONE);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("bad decrement skip");

    property p_inc_skip;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_INC_SKIP |-> result == 8'(rd_data_i + IDLE_ONE);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("bad increment skip");

    // flag passes through untouched so a core that loads it anyway sees no change
    property p_flag_pass;
        @(posedge clock_i) disable iff (srst_i)
        !(valid_i && flag_we) |=> !zero_we_o && zero_flag_o == $past(zero_flag_i);
    endproperty
    a_flag_pass: assert property (p_flag_pass) else $error("flag not passed through");

    // wrap is the boundary most likely to break if the datapath width ever changes
    property p_inc_wrap;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_INC && rd_data_i == ~IDLE_ZERO |-> result == IDLE_ZERO
            && res_zero;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment did not wrap");

    // decrement of zero must give all ones and leave the zero result low
    property p_dec_wrap;
        @(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_DEC && rd_data_i == IDLE_ZERO |-> result == ~IDLE_ZERO
            && !res_zero;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap) else $error("decrement did not wrap");

    c_skip: cover property (@(posedge clock_i) disable iff (srst_i) skip_o);
    c_wrap: cover property (@(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_INC && rd_data_i == 8'hFF);
    c_file: cover property (@(posedge clock_i) disable iff (srst_i) wr_en_o);
    c_dec_wrap: cover property (@(posedge clock_i) disable iff (srst_i)
        valid_i && op_i == IDLE_OP_DEC && rd_data_i == IDLE_ZERO);
    c_b2b: cover property (@(posedge clock_i) disable iff (srst_i)
        valid_i ##1 (valid_i && op_i == IDLE_OP_OR_LIT));
endmodule

// File: design/idle_pkg.sv
package idle_pkg;
    localparam int IDLE_DATA_W = 8;
    localparam int IDLE_ADDR_W = 7;
    localparam logic [7:0] IDLE_ONE = 8'h01;
    localparam logic [7:0] IDLE_ZERO = 8'h00;
    localparam logic [7:0] IDLE_ACC_RST = 8'h00;
    localparam logic IDLE_DEST_ACC = 1'b0;
    localparam logic IDLE_DEST_FILE = 1'b1;
    typedef enum logic [2:0] {
        IDLE_OP_DEC = 3'h0,
        IDLE_OP_INC = 3'h1,
        IDLE_OP_DEC_SKIP = 3'h2,
        IDLE_OP_INC_SKIP = 3'h3,
        IDLE_OP_OR_LIT = 3'h4,
        IDLE_OP_LOAD_LIT = 3'h5
    } idle_op_t;
endpackage

// File: design/idle_alu.sv
`timescale 1ns/1ps
module idle_alu
    import idle_pkg::*;
(
    // operation
    input wire idle_pkg::idle_op_t op_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] lit_i,
    // result
    output logic [7:0] result_o,
    output logic zero_o,
    output logic writes_flag_o,
    output logic skip_kind_o
);
    import idle_pkg::*;

    always_comb begin
        result_o = IDLE_ZERO;
        writes_flag_o = 1'b0;
        skip_kind_o = 1'b0;
        case (op_i)
            IDLE_OP_DEC: begin
                result_o = file_i - IDLE_ONE;
                writes_flag_o = 1'b1;
            end
            IDLE_OP_INC: begin
                result_o = file_i + IDLE_ONE;
                writes_flag_o = 1'b1;
            end
            IDLE_OP_DEC_SKIP: begin
                result_o = file_i - IDLE_ONE;
                skip_kind_o = 1'b1;
            end
            IDLE_OP_INC_SKIP: begin
                result_o = file_i + IDLE_ONE;
                skip_kind_o = 1'b1;
            end
            IDLE_OP_OR_LIT: begin
                result_o = acc_i | lit_i;
                writes_flag_o = 1'b1;
            end
            IDLE_OP_LOAD_LIT: begin
                result_o = lit_i;
            end
            default: begin
                result_o = IDLE_ZERO;
            end
        endcase
        zero_o = (result_o == IDLE_ZERO);
    end
endmodule

// File: verif/idle_exec_tb.sv
`timescale 1ns/1ps
module idle_exec_tb;
    import idle_pkg::*;
    logic clock_i = 0;
    logic srst_i = 1;
    logic valid_i = 0;
    logic dest_i = 0;
    logic zero_flag_i = 0;
    idle_op_t op_i = IDLE_OP_DEC;
    logic [6:0] addr_i = 7'h00;
    logic [7:0] lit_i = 8'h00;
    logic [7:0] rd_data_i = 8'h00;
    logic [6:0] rd_addr_o, wr_addr_o;
    logic [7:0] wr_data_o, acc_o;
    logic wr_en_o, zero_flag_o, zero_we_o, skip_o;
    logic [7:0] acc_x = 8'h00;
    int n_mismatch = 0;
    int n_compared = 0;
    always #25 clock_i = ~clock_i;
    idle_exec uut (.clock_i(clock_i), .srst_i(srst_i), .valid_i(valid_i), .op_i(op_i),
        .addr_i(addr_i), .dest_i(dest_i), .lit_i(lit_i), .rd_addr_o(rd_addr_o),
        .rd_data_i(rd_data_i), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
        .wr_data_o(wr_data_o), .zero_flag_i(zero_flag_i), .acc_o(acc_o),
        .zero_flag_o(zero_flag_o), .zero_we_o(zero_we_o), .skip_o(skip_o));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one instruction, judged 1 ns after the taking edge, pulses low one cycle later
    task automatic run(input idle_op_t op, input logic [6:0] a, input logic d,
            input logic [7:0] k, input logic [7:0] rd, input logic z);
        logic [7:0] res;
        logic lit, wb, we, sk;
        lit = op inside {IDLE_OP_OR_LIT, IDLE_OP_LOAD_LIT};
        wb = !lit && d;
        we = op inside {IDLE_OP_DEC, IDLE_OP_INC, IDLE_OP_OR_LIT};
        case (op)
            IDLE_OP_DEC, IDLE_OP_DEC_SKIP: res = rd - 8'h01;
            IDLE_OP_INC, IDLE_OP_INC_SKIP: res = rd + 8'h01;
            IDLE_OP_OR_LIT: res = acc_x | k;
            default: res = k;
        endcase
        sk = !lit && !we && res == 8'h00;
        @(posedge clock_i);
        valid_i <= 1'b1;
        op_i <= op;
        addr_i <= a;
        dest_i <= d;
        lit_i <= k;
        rd_data_i <= rd;
        zero_flag_i <= z;
        @(posedge clock_i);
        valid_i <= 1'b0;
        #1;
        if (!wb) acc_x = res;
        chk({1'b0, rd_addr_o}, {1'b0, a});
        chk({7'h00, wr_en_o}, {7'h00, wb});
        if (wb) chk({1'b0, wr_addr_o}, {1'b0, a});
        if (wb) chk(wr_data_o, res);
        chk(acc_o, acc_x);
        chk({7'h00, zero_we_o}, {7'h00, we});
        chk({7'h00, zero_flag_o}, {7'h00, we ? res == 8'h00 : z});
        chk({7'h00, skip_o}, {7'h00, sk});
        @(posedge clock_i);
        #1;
        chk({5'h00, wr_en_o, zero_we_o, skip_o}, 8'h00);
    endtask
    task automatic t_reset();
        chk(acc_o, IDLE_ACC_RST);
        chk({4'h0, wr_en_o, zero_we_o, skip_o, zero_flag_o}, 8'h00);
        $display("reset test done");
    endtask
    // wrap and zero boundaries, both destinations, both address ends
    task automatic t_regops();
        logic [7:0] vals [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
        for (int o = 0; o < 4; o++) begin
            for (int v = 0; v < 8; v++) begin
                run(idle_op_t'(o), v[0] ? 7'h7F : 7'h00, v[2], 8'h5A, vals[v % 4], v[1]);
            end
        end
        $display("register ops test done");
    endtask
    task automatic t_lit();
        run(IDLE_OP_LOAD_LIT, 7'h05, 1'b1, 8'h00, 8'h11, 1'b1);
        run(IDLE_OP_OR_LIT, 7'h05, 1'b1, 8'h00, 8'h11, 1'b0);
        run(IDLE_OP_OR_LIT, 7'h05, 1'b0, 8'hA5, 8'h00, 1'b1);
        run(IDLE_OP_LOAD_LIT, 7'h05, 1'b0, 8'h3C, 8'h00, 1'b0);
        $display("literal test done");
    endtask
    // accumulator must be forwarded between back to back literal ops
    task automatic t_b2b();
        @(posedge clock_i);
        valid_i <= 1'b1;
        op_i <= IDLE_OP_LOAD_LIT;
        lit_i <= 8'h0F;
        @(posedge clock_i);
        op_i <= IDLE_OP_OR_LIT;
        lit_i <= 8'hF0;
        @(posedge clock_i);
        valid_i <= 1'b0;
        #1;
        chk(acc_o, 8'hFF);
        chk({5'h00, wr_en_o, zero_we_o, zero_flag_o}, 8'h02);
        acc_x = 8'hFF;
        $display("back to back test done");
    endtask
    // reset raised with a skipping instruction pending must discard it
    task automatic t_mid_reset();
        @(posedge clock_i);
        srst_i <= 1'b1;
        valid_i <= 1'b1;
        op_i <= IDLE_OP_INC_SKIP;
        dest_i <= 1'b1;
        rd_data_i <= 8'hFF;
        zero_flag_i <= 1'b0;
        @(posedge clock_i);
        valid_i <= 1'b0;
        @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(acc_o, IDLE_ACC_RST);
        chk({4'h0, wr_en_o, zero_we_o, skip_o, zero_flag_o}, 8'h00);
        acc_x = IDLE_ACC_RST;
        run(IDLE_OP_OR_LIT, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
        $display("mid-run reset test done");
    endtask
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        t_reset();
        t_regops();
        t_lit();
        t_b2b();
        t_mid_reset();
        give_verdict();
    end
endmodule
